// file: design/ifr_tx_pkg.sv
// Purpose: shared constants and types for the response transmit control
// Assumes: 32-bit axi4-lite register access, one aligned word per register
// Notes:   register offsets are byte addresses
package ifr_tx_pkg;

    localparam int          AXI_ADDR_W      = 8;

    // register byte offsets
    localparam logic [7:0]  CTRL_OFFSET     = 8'h00;
    localparam logic [7:0]  DATA_OFFSET     = 8'h04;
    localparam logic [7:0]  STATUS_OFFSET   = 8'h08;

    // field positions in link_transmit_control
    localparam int          NOCRC_REQ_BIT   = 0;
    localparam int          CRC_REQ_BIT     = 1;
    localparam int          SINGLE_REQ_BIT  = 2;
    localparam int          EOT_REQ_BIT     = 3;
    localparam int          NORM_BIT_FORMAT_SELECT_BIT        = 4;

    // field positions in status
    localparam int          HOLD_EMPTY_BIT  = 0;
    localparam int          LOST_ARB_BIT    = 1;
    localparam int          BUSY_BIT        = 2;
    localparam int          EOD_PASSED_BIT  = 3;

    // values after reset
    localparam logic [2:0]  REQ_RESET       = 3'h0;
    localparam logic [7:0]  DATA_RESET      = 8'h00;

    // axi responses
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    typedef enum logic [2:0] {
        OP_NORM,
        OP_BYTE,
        OP_CRC,
        OP_EOD,
        OP_ONES
    } tx_op_type;

    typedef enum logic [1:0] {
        MODE_SINGLE,
        MODE_CRC,
        MODE_NOCRC
    } resp_mode_type;

    // command to the symbol transmitter; data[0] carries the nb value
    typedef struct packed {
        tx_op_type   op;
        logic [7:0]  data;
    } tx_cmd_type;

    // one-cycle events from the symbol layer
    typedef struct packed {
        logic eod_rx;        // valid eod seen, no crc error
        logic eof_rx;        // frame over
        logic done;          // last command finished and won
        logic arb_lost;      // last command lost arbitration
        logic arb_late;      // loss fell within the last two bits
        logic bus_error;     // any bus fault
        logic win_byte_end;  // the winning byte has completed
    } link_evt_type;

endpackage : ifr_tx_pkg

// file: design/ifr_tx_ctrl.sv
// Purpose: in-frame response transmit control with axi4-lite registers
// Assumes: symbol layer on the same clock issues one-cycle events
// Notes:   bit timing, crc arithmetic and arbitration live downstream
//
// Chosen here: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
module ifr_tx_ctrl (
    // clock and reset
    input  wire logic                          core_clk_in,
    input  wire logic                          reset_n_in,
    // axi4-lite write
    input  wire logic [ifr_tx_pkg::AXI_ADDR_W-1:0] s_axi_awaddr_in,
    input  wire logic                          s_axi_awvalid_in,
    output logic                               s_axi_awready_out,
    input  wire logic [31:0]                   s_axi_wdata_in,
    input  wire logic [3:0]                    s_axi_wstrb_in,
    input  wire logic                          s_axi_wvalid_in,
    output logic                               s_axi_wready_out,
    output logic [1:0]                         s_axi_bresp_out,
    output logic                               s_axi_bvalid_out,
    input  wire logic                          s_axi_bready_in,
    // axi4-lite read
    input  wire logic [ifr_tx_pkg::AXI_ADDR_W-1:0] s_axi_araddr_in,
    input  wire logic                          s_axi_arvalid_in,
    output logic                               s_axi_arready_out,
    output logic [31:0]                        s_axi_rdata_out,
    output logic [1:0]                         s_axi_rresp_out,
    output logic                               s_axi_rvalid_out,
    input  wire logic                          s_axi_rready_in,
    // symbol layer
    input  wire ifr_tx_pkg::link_evt_type      link_evt_in,
    output ifr_tx_pkg::tx_cmd_type             tx_cmd_out,
    output logic                               tx_cmd_start_out
);
    import ifr_tx_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_NORM,
        ST_BYTE,
        ST_WAIT_WIN,
        ST_CRC,
        ST_EOD,
        ST_ONES
    } state_type;

    // bus slave state
    logic                  awready_ff, wready_ff, bvalid_ff;
    logic                  arready_ff, rvalid_ff;
    logic [1:0]            bresp_ff, rresp_ff;
    logic [31:0]           rdata_ff;
    logic                  aw_full_ff, w_full_ff;
    logic [AXI_ADDR_W-1:0] aw_addr_ff;
    logic [7:0]            w_data_ff;
    logic                  w_lane0_ff;

    // block state
    logic [2:0]            req_ff;
    logic                  eot_ff, norm_bit_format_select_ff;
    logic [7:0]            data_ff, shift_ff;
    logic                  hold_full_ff, hold_empty_ff, lost_ff;
    logic                  eod_passed_ff;
    state_type             state_ff, nxt_state;
    resp_mode_type         mode_ff, nxt_mode;
    tx_cmd_type            cmd_ff, nxt_cmd;
    logic                  cmd_start_ff, nxt_cmd_start;

    // write decode
    wire wr_fire   = aw_full_ff & w_full_ff & ~bvalid_ff;
    wire sel_ctrl  = aw_addr_ff == CTRL_OFFSET;
    wire sel_data  = aw_addr_ff == DATA_OFFSET;
    wire sel_stat  = aw_addr_ff == STATUS_OFFSET;
    wire wr_ok     = sel_ctrl | sel_data | sel_stat;
    wire wr_ctrl   = wr_fire & sel_ctrl & w_lane0_ff;
    wire wr_data   = wr_fire & sel_data & w_lane0_ff;
    wire wr_stat   = wr_fire & sel_stat & w_lane0_ff;
    wire eot_write = wr_ctrl & w_data_ff[EOT_REQ_BIT];
    wire lost_w1c  = wr_stat & w_data_ff[LOST_ARB_BIT];

    // read decode
    wire ar_fire   = s_axi_arvalid_in & arready_ff;
    wire rd_ctrl   = s_axi_araddr_in == CTRL_OFFSET;
    wire rd_data   = s_axi_araddr_in == DATA_OFFSET;
    wire rd_stat   = s_axi_araddr_in == STATUS_OFFSET;
    wire rd_ok     = rd_ctrl | rd_data | rd_stat;
    wire busy      = state_ff != ST_IDLE;
    wire [31:0] ctrl_word = {27'h000_0000, norm_bit_format_select_ff, eot_ff, req_ff};
    wire [31:0] stat_word = {28'h000_0000, eod_passed_ff, busy, lost_ff,
                             hold_empty_ff};
    wire [31:0] rd_word   = rd_ctrl ? ctrl_word :
                            rd_data ? {24'h00_0000, data_ff} :
                            rd_stat ? stat_word : 32'h0000_0000;

    // effective mode by priority; raw bits stay readable
    wire any_req    = |req_ff;
    wire [1:0] eff_mode = req_ff[SINGLE_REQ_BIT] ? MODE_SINGLE :
                          req_ff[CRC_REQ_BIT]    ? MODE_CRC    :
                                                   MODE_NOCRC;
    wire start_resp = (state_ff == ST_IDLE) & link_evt_in.eod_rx &
                      any_req & ~eod_passed_ff;
    wire start_crc  = eff_mode == MODE_CRC;
    wire run_crc    = (state_ff == ST_IDLE) ? start_crc
                                            : mode_ff == MODE_CRC;
    // crc-ended responses use nb=~norm_bit_format_select, others nb=norm_bit_format_select
    wire norm_val   = run_crc ? ~norm_bit_format_select_ff : norm_bit_format_select_ff;
    wire multi      = mode_ff != MODE_SINGLE;
    wire in_tx      = (state_ff == ST_BYTE) | (state_ff == ST_CRC) |
                      (state_ff == ST_EOD);
    wire abort_err  = busy & link_evt_in.bus_error;
    wire abort_eot  = busy & (mode_ff == MODE_SINGLE) & eot_ff;
    wire refill     = hold_full_ff;

    // response sequencer
    logic clr_req, clr_eot, set_lost, load_first, load_next;
    always_comb begin
        nxt_state     = state_ff;
        nxt_mode      = mode_ff;
        nxt_cmd       = cmd_ff;
        nxt_cmd_start = 1'b0;
        clr_req       = 1'b0;
        clr_eot       = 1'b0;
        set_lost      = 1'b0;
        load_first    = 1'b0;
        load_next     = 1'b0;
        if (abort_err || abort_eot) begin
            nxt_state = ST_IDLE;
            clr_req   = 1'b1;
            clr_eot   = 1'b1;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    if (start_resp) begin
                        nxt_mode      = resp_mode_type'(eff_mode);
                        load_first    = 1'b1;
                        nxt_state     = ST_NORM;
                        nxt_cmd       = '{OP_NORM, {7'h00, norm_val}};
                        nxt_cmd_start = 1'b1;
                    end
                    if (link_evt_in.eod_rx || link_evt_in.bus_error) begin
                        clr_eot = 1'b1;
                    end
                end
                // a lost nb means another responder's nb is on the bus:
                // follow it and go straight on to the byte
                ST_NORM: begin
                    if (link_evt_in.done || link_evt_in.arb_lost) begin
                        nxt_state     = ST_BYTE;
                        nxt_cmd       = '{OP_BYTE, shift_ff};
                        nxt_cmd_start = 1'b1;
                    end
                end
                ST_BYTE: begin
                    if (link_evt_in.arb_lost && !multi) begin
                        nxt_state = ST_WAIT_WIN;
                    end else if (link_evt_in.arb_lost) begin
                        set_lost = 1'b1;
                        clr_req  = 1'b1;
                        clr_eot  = 1'b1;
                        if (link_evt_in.arb_late) begin
                            nxt_state     = ST_ONES;
                            nxt_cmd       = '{OP_ONES, 8'h00};
                            nxt_cmd_start = 1'b1;
                        end else begin
                            nxt_state = ST_IDLE;
                        end
                    end else if (link_evt_in.done && !multi) begin
                        nxt_state = ST_IDLE;
                        clr_req   = 1'b1;
                    end else if (link_evt_in.done && refill) begin
                        load_next     = 1'b1;
                        nxt_cmd       = '{OP_BYTE, data_ff};
                        nxt_cmd_start = 1'b1;
                    end else if (link_evt_in.done && eot_ff) begin
                        nxt_state     = (mode_ff == MODE_CRC) ? ST_CRC
                                                              : ST_EOD;
                        nxt_cmd       = (mode_ff == MODE_CRC) ?
                                        tx_cmd_type'{OP_CRC, 8'h00} :
                                        tx_cmd_type'{OP_EOD, 8'h00};
                        nxt_cmd_start = 1'b1;
                    end else if (link_evt_in.done) begin
                        // underrun: close on a broken byte boundary
                        nxt_state     = ST_ONES;
                        nxt_cmd       = '{OP_ONES, 8'h00};
                        nxt_cmd_start = 1'b1;
                        clr_req       = 1'b1;
                    end
                end
                ST_WAIT_WIN: begin
                    if (link_evt_in.win_byte_end) begin
                        nxt_state     = ST_BYTE;
                        nxt_cmd       = '{OP_BYTE, shift_ff};
                        nxt_cmd_start = 1'b1;
                    end
                end
                ST_CRC: begin
                    if (link_evt_in.arb_lost) begin
                        set_lost  = 1'b1;
                        clr_req   = 1'b1;
                        clr_eot   = 1'b1;
                        nxt_state = ST_IDLE;
                    end else if (link_evt_in.done) begin
                        nxt_state     = ST_EOD;
                        nxt_cmd       = '{OP_EOD, 8'h00};
                        nxt_cmd_start = 1'b1;
                    end
                end
                ST_EOD: begin
                    if (link_evt_in.done || link_evt_in.arb_lost) begin
                        nxt_state = ST_IDLE;
                        clr_req   = 1'b1;
                        clr_eot   = 1'b1;
                        set_lost  = link_evt_in.arb_lost;
                    end
                end
                ST_ONES: begin
                    if (link_evt_in.done) begin
                        nxt_state = ST_IDLE;
                        clr_req   = 1'b1;
                    end
                end
                default: nxt_state = ST_IDLE;
            endcase
        end
    end

    // bus slave handshakes
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            awready_ff <= 1'b1;
            wready_ff  <= 1'b1;
            aw_full_ff <= 1'b0;
            w_full_ff  <= 1'b0;
            aw_addr_ff <= '0;
            w_data_ff  <= 8'h00;
            w_lane0_ff <= 1'b0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid_in && awready_ff) begin
                aw_full_ff <= 1'b1;
                awready_ff <= 1'b0;
                aw_addr_ff <= s_axi_awaddr_in;
            end
            if (s_axi_wvalid_in && wready_ff) begin
                w_full_ff  <= 1'b1;
                wready_ff  <= 1'b0;
                w_data_ff  <= s_axi_wdata_in[7:0];
                w_lane0_ff <= s_axi_wstrb_in[0];
            end
            if (wr_fire) begin
                bvalid_ff <= 1'b1;
                bresp_ff  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end
            if (bvalid_ff && s_axi_bready_in) begin
                bvalid_ff  <= 1'b0;
                aw_full_ff <= 1'b0;
                w_full_ff  <= 1'b0;
                awready_ff <= 1'b1;
                wready_ff  <= 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            arready_ff <= 1'b1;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= 32'h0000_0000;
            rresp_ff   <= RESP_OKAY;
        end else if (ar_fire) begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b1;
            rdata_ff   <= rd_word;
            rresp_ff   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_ff && s_axi_rready_in) begin
            arready_ff <= 1'b1;
            rvalid_ff  <= 1'b0;
        end
    end

    // control register: a new write beats an auto-clear in the same cycle
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            req_ff  <= REQ_RESET;
            eot_ff  <= 1'b0;
            norm_bit_format_select_ff <= 1'b0;
        end else if (wr_ctrl) begin
            // after eod, request bits cannot be raised
            req_ff  <= eod_passed_ff ? (req_ff & w_data_ff[2:0])
                                     : w_data_ff[2:0];
            eot_ff  <= w_data_ff[EOT_REQ_BIT];
            norm_bit_format_select_ff <= w_data_ff[NORM_BIT_FORMAT_SELECT_BIT];
        end else begin
            if (clr_req) req_ff <= REQ_RESET;
            if (clr_eot) eot_ff <= 1'b0;
        end
    end

    // data holding and shift bytes; flags favour the hardware set
    wire multi_next = (state_ff == ST_IDLE) ? (eff_mode != MODE_SINGLE)
                                            : multi;
    wire set_empty = (load_first | load_next) & multi_next;
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            data_ff       <= DATA_RESET;
            shift_ff      <= DATA_RESET;
            hold_full_ff  <= 1'b0;
            hold_empty_ff <= 1'b0;
            lost_ff       <= 1'b0;
        end else begin
            if (load_first || load_next) begin
                shift_ff     <= data_ff;
                hold_full_ff <= 1'b0;
            end
            if (wr_data) begin
                data_ff      <= w_data_ff;
                hold_full_ff <= busy | (load_first & 1'b0);
            end
            if (set_empty) begin
                hold_empty_ff <= 1'b1;
            end else if (wr_data || eot_write || !busy) begin
                hold_empty_ff <= 1'b0;
            end
            if (set_lost) begin
                lost_ff <= 1'b1;
            end else if (lost_w1c) begin
                lost_ff <= 1'b0;
            end
        end
    end

    // eod window, state and command registers
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            eod_passed_ff <= 1'b0;
            state_ff      <= ST_IDLE;
            mode_ff       <= MODE_NOCRC;
            cmd_ff        <= '{OP_NORM, 8'h00};
            cmd_start_ff  <= 1'b0;
        end else begin
            if (link_evt_in.eod_rx) begin
                eod_passed_ff <= 1'b1;
            end else if (link_evt_in.eof_rx) begin
                eod_passed_ff <= 1'b0;
            end
            state_ff     <= nxt_state;
            mode_ff      <= nxt_mode;
            cmd_ff       <= nxt_cmd;
            cmd_start_ff <= nxt_cmd_start;
        end
    end

    assign s_axi_awready_out = awready_ff;
    assign s_axi_wready_out  = wready_ff;
    assign s_axi_bvalid_out  = bvalid_ff;
    assign s_axi_bresp_out   = bresp_ff;
    assign s_axi_arready_out = arready_ff;
    assign s_axi_rvalid_out  = rvalid_ff;
    assign s_axi_rdata_out   = rdata_ff;
    assign s_axi_rresp_out   = rresp_ff;
    assign tx_cmd_out        = cmd_ff;
    assign tx_cmd_start_out  = cmd_start_ff;

    // checks
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!reset_n_in);

    wire quiet = ~link_evt_in.bus_error;

    a_norm_first: assert property (start_resp && quiet |=>
        tx_cmd_start_out && tx_cmd_out.op == OP_NORM)
        else $error("response did not open with a normalization bit");
    a_norm_value: assert property (start_resp && quiet |=>
        tx_cmd_out.data[0] == ($past(norm_bit_format_select_ff) ^
        ($past(req_ff[CRC_REQ_BIT]) & ~$past(req_ff[SINGLE_REQ_BIT]))))
        else $error("normalization bit value wrong");
    a_late_request: assert property (wr_ctrl && eod_passed_ff &&
        req_ff == 3'h0 |=> req_ff == 3'h0)
        else $error("request accepted after eod");
    a_single_retry: assert property (state_ff == ST_BYTE &&
        mode_ff == MODE_SINGLE && link_evt_in.arb_lost && quiet &&
        !eot_ff |=> state_ff == ST_WAIT_WIN && !tx_cmd_start_out)
        else $error("single response did not wait after loss");
    a_retry_no_norm: assert property (state_ff == ST_WAIT_WIN &&
        link_evt_in.win_byte_end && quiet && !eot_ff |=>
        tx_cmd_start_out && tx_cmd_out.op == OP_BYTE)
        else $error("retry missing or sent a normalization bit");
    a_multi_loss: assert property (state_ff == ST_BYTE && multi &&
        link_evt_in.arb_lost && quiet |=> lost_ff && req_ff == 3'h0 &&
        state_ff != ST_BYTE)
        else $error("multi loss not flagged and stopped");
    a_late_ones: assert property (state_ff == ST_BYTE && multi &&
        link_evt_in.arb_lost && link_evt_in.arb_late && quiet |=>
        tx_cmd_out.op == OP_ONES ##1 !tx_cmd_start_out)
        else $error("late loss did not send two ones");
    a_crc_tail: assert property (state_ff == ST_BYTE &&
        mode_ff == MODE_CRC && link_evt_in.done && !hold_full_ff &&
        eot_ff && quiet |=> tx_cmd_out.op == OP_CRC)
        else $error("crc not sent after last byte");
    a_nocrc_tail: assert property (state_ff == ST_BYTE &&
        mode_ff == MODE_NOCRC && link_evt_in.done && !hold_full_ff &&
        eot_ff && quiet |=> tx_cmd_out.op == OP_EOD)
        else $error("eod not sent straight after last byte");
    a_error_clear: assert property (busy && link_evt_in.bus_error &&
        !wr_ctrl |=> req_ff == 3'h0 && !eot_ff && state_ff == ST_IDLE)
        else $error("bus error did not end the response");
    a_mode_prio: assert property (start_resp && req_ff == 3'h3 &&
        quiet |=> mode_ff == MODE_CRC && $stable(req_ff) || wr_ctrl)
        else $error("priority encoding wrong");

    c_single_done: cover property (state_ff == ST_BYTE &&
        mode_ff == MODE_SINGLE && link_evt_in.done);
    c_crc_end: cover property (state_ff == ST_CRC ##[1:40]
        state_ff == ST_IDLE);
    c_late_loss: cover property (state_ff == ST_ONES);
    c_retry: cover property (state_ff == ST_WAIT_WIN ##[1:40]
        state_ff == ST_BYTE);

endmodule : ifr_tx_ctrl

// file: tb/link_partner.sv
// Purpose: symbol layer and far bus stand-in for the response controller
// Assumes: each command takes DELAY cycles on the wire
// Notes:   lose_in makes the next byte lose; the winner ends DELAY later
`timescale 1ns/1ps
module link_partner #(parameter int DELAY = 20) (
    // clock and reset
    input  wire logic                     core_clk_in,
    input  wire logic                     reset_n_in,
    // controller side and bench controls
    input  wire ifr_tx_pkg::tx_cmd_type   cmd_in,
    input  wire logic                     start_in,
    input  wire logic                     lose_in,
    input  wire logic [1:0]               frame_in,
    // events back
    output ifr_tx_pkg::link_evt_type      evt_out
);
    import ifr_tx_pkg::*;
    int cnt_ff;
    int win_ff;
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cnt_ff <= 0;
            win_ff <= 0;
            evt_out <= '0;
        end else begin
            evt_out <= '0;
            evt_out.eod_rx <= frame_in[1];
            evt_out.eof_rx <= frame_in[0];
            cnt_ff <= start_in ? DELAY : (cnt_ff > 0 ? cnt_ff - 1 : 0);
            if (win_ff > 0) win_ff <= win_ff - 1;
            if (win_ff == 1) evt_out.win_byte_end <= 1'b1;
            if (cnt_ff == 1 && lose_in && cmd_in.op == OP_BYTE) begin
                evt_out.arb_lost <= 1'b1;
                win_ff <= DELAY;
            end else if (cnt_ff == 1) evt_out.done <= 1'b1;
        end
    end
endmodule : link_partner

// file: tb/j1850_ifr_transmit_control_test.sv
// Purpose: self-checking bench for the response transmit controller
// Assumes: axi4-lite master tasks, partner answers every command
// Notes:   eof is pulsed before each response so eod can start one
`timescale 1ns/1ps
module j1850_ifr_transmit_control_test;
    import ifr_tx_pkg::*;
    logic core_clk_in = 0, reset_n_in = 0, lose = 0, start;
    logic [7:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata, d;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, r, frame = '0;
    link_evt_type evt;
    tx_cmd_type cmd, ops[$];
    int mismatches = 0, n_checks = 0;
    always #5 core_clk_in = ~core_clk_in;
    ifr_tx_ctrl DUT (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
        .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
        .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
        .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid),
        .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
        .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
        .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
        .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
        .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
        .s_axi_rready_in(rready), .link_evt_in(evt),
        .tx_cmd_out(cmd), .tx_cmd_start_out(start));
    link_partner partner (.core_clk_in(core_clk_in),
        .reset_n_in(reset_n_in), .cmd_in(cmd), .start_in(start),
        .lose_in(lose), .frame_in(frame), .evt_out(evt));
    always @(posedge core_clk_in) if (start) ops.push_back(cmd);
    always @(posedge core_clk_in) if (evt.arb_lost) lose <= 1'b0;
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
            mismatches++;
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge core_clk_in);
        awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
        do begin
            @(posedge core_clk_in);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        chk("bresp", RESP_OKAY, bresp);
    endtask : wr
    task rd(input logic [7:0] a);
        @(posedge core_clk_in);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do begin
            @(posedge core_clk_in);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata; r = rresp;
        rready <= 1'b0;
    endtask : rd
    task pulse(input logic [1:0] f);
        @(posedge core_clk_in) frame <= f;
        @(posedge core_clk_in) frame <= 2'b00;
    endtask : pulse
    task wait_ops(input int n);
        for (int i = 0; i < 3000 && ops.size() < n; i++) @(posedge core_clk_in);
        repeat (40) @(posedge core_clk_in);
        chk("ops", n, ops.size());
        rd(CTRL_OFFSET);
    endtask : wait_ops
    task t_multi_crc;
        pulse(2'b01); ops.delete();
        wr(DATA_OFFSET, 32'h0000_00A5);
        wr(CTRL_OFFSET, 32'h0000_0003);
        rd(CTRL_OFFSET); chk("raw", 32'h0000_0003, d);
        pulse(2'b10); d = '0;
        for (int i = 0; i < 50 && !d[HOLD_EMPTY_BIT]; i++) rd(STATUS_OFFSET);
        chk("empty set", 1, d[HOLD_EMPTY_BIT]);
        wr(CTRL_OFFSET, 32'h0000_000B);
        rd(STATUS_OFFSET); chk("empty", 0, d[HOLD_EMPTY_BIT]);
        wait_ops(4); chk("ctrl", 0, d[3:0]);
        chk("nb", {OP_NORM, 8'h01}, ops[0]);
        chk("byte", {OP_BYTE, 8'hA5}, ops[1]);
        chk("crc", {OP_CRC, 8'h00}, ops[2] & 11'h700);
        chk("eod", {OP_EOD, 8'h00}, ops[3] & 11'h700);
    endtask : t_multi_crc
    task t_single_retry;
        pulse(2'b01); ops.delete();
        wr(DATA_OFFSET, 32'h0000_003C);
        wr(CTRL_OFFSET, 32'h0000_0004);
        lose <= 1'b1; pulse(2'b10);
        wait_ops(3); chk("ctrl", 0, d[2:0]);
        chk("nb", {OP_NORM, 8'h00}, ops[0]);
        chk("byte", {OP_BYTE, 8'h3C}, ops[1]);
        chk("retry", {OP_BYTE, 8'h3C}, ops[2]);
    endtask : t_single_retry
    task t_multi_nocrc;
        pulse(2'b01); ops.delete();
        wr(DATA_OFFSET, 32'h0000_0011);
        wr(CTRL_OFFSET, 32'h0000_0011);
        pulse(2'b10); d = '0;
        for (int i = 0; i < 50 && !d[HOLD_EMPTY_BIT]; i++) rd(STATUS_OFFSET);
        chk("empty set", 1, d[HOLD_EMPTY_BIT]);
        wr(DATA_OFFSET, 32'h0000_0022);
        wr(CTRL_OFFSET, 32'h0000_0019);
        wait_ops(4); chk("ctrl", 0, d[3:0]);
        chk("nb", {OP_NORM, 8'h01}, ops[0]);
        chk("byte1", {OP_BYTE, 8'h11}, ops[1]);
        chk("byte2", {OP_BYTE, 8'h22}, ops[2]);
        chk("eod", {OP_EOD, 8'h00}, ops[3] & 11'h700);
    endtask : t_multi_nocrc
    task t_multi_loss;
        pulse(2'b01); ops.delete();
        wr(CTRL_OFFSET, 32'h0000_0002);
        lose <= 1'b1; pulse(2'b10);
        wait_ops(2); chk("ctrl", 0, d[2:0]);
        repeat (40) @(posedge core_clk_in);
        chk("no retry", 2, ops.size());
        chk("lost byte", {OP_BYTE, 8'h22}, ops[1]);
        rd(STATUS_OFFSET); chk("lost", 1, d[LOST_ARB_BIT]);
        wr(STATUS_OFFSET, 32'h0000_0002);
        rd(STATUS_OFFSET); chk("lost clear", 0, d[LOST_ARB_BIT]);
    endtask : t_multi_loss
    task t_late_request;
        pulse(2'b01); pulse(2'b10); ops.delete();
        wr(CTRL_OFFSET, 32'h0000_0004);
        wait_ops(0); chk("late", 0, d[2:0]);
        rd(8'h0C); chk("unmapped", RESP_SLVERR, r);
    endtask : t_late_request
    task conclude;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : conclude
    initial begin
        repeat (10) @(posedge core_clk_in);
        reset_n_in <= 1'b1;
        t_multi_crc();
        t_single_retry();
        t_multi_nocrc();
        t_multi_loss();
        t_late_request();
        conclude();
    end
    initial begin
        #500us;
        mismatches++;
        conclude();
    end
endmodule : j1850_ifr_transmit_control_test
